// ---- pkg/codec_ctrl_consts.vh ----
// Register map, field positions, reset values and timing counts of the codec control block
`ifndef CODEC_CTRL_CONSTS_VH
`define CODEC_CTRL_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_CLR 8'h0C
`define OFS_IRQ_EN 8'h10
`define OFS_DAC_DATA 8'h14
`define OFS_ADC_CODE 8'h18

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_MODE_CHANGE 0
`define CTRL_CAL_ON_EXIT 1
`define CTRL_CDS_LO 2
`define CTRL_CDS_HI 4
`define CTRL_CSS 5
`define CTRL_FMT_LO 6
`define CTRL_FMT_HI 7
`define CTRL_MISC_LO 8
`define CTRL_MISC_HI 15
`define CTRL_RESET 16'h0001

// ----------------------------------------
// Status and interrupt bit positions
// ----------------------------------------
`define ST_CAL_BUSY 0
`define ST_RESYNC 1
`define ST_PORT_OFF 2
`define ST_DONE_FIRST 3
`define EV_CAL_DONE 0
`define EV_RESYNC_SET 1
`define EV_PORT_READY 2
`define EV_WRITE_IGNORED 3
`define EV_COUNT 4

// ----------------------------------------
// Sample encodings
// ----------------------------------------
`define FMT_LIN16 2'b00
`define FMT_ULAW 2'b01
`define FMT_UNS8 2'b10
`define FMT_ALAW 2'b11

// ----------------------------------------
// Timing in sample periods and serial clocks
// ----------------------------------------
`define CAL_SAMPLES 9'h180
`define MUTE_SAMPLES 9'h080
`define RESYNC_EXP 21
`define RESYNC_FIRST_SCLKS 22'h20_0000
`define SCLK_RATE_KHZ 12288
`define RESYNC_LATER_MS 5
// Later timeout: 5 ms of a 12.288 MHz serial clock
`define RESYNC_LATER_SCLKS 22'h00_F000

`endif

// ---- rtl/sample_formatter.v ----
// Encodes a 16-bit capture sample into the selected sample encoding
`timescale 1ns/1ps
`include "codec_ctrl_consts.vh"

module sample_formatter (
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  input wire [1:0] fmt,
  input wire [15:0] sampleIn,
  input wire sampleValid,
  output reg [15:0] codeOut_r,
  output reg codeValid_r
);

  // ----------------------------------------
  // Mu-law, bias 132, clip 32635
  // ----------------------------------------
  function [7:0] ulawEnc;
    input [15:0] s;
    reg [16:0] mag;
    reg [2:0] ex;
    reg [3:0] man;
    integer i;
    begin
      mag = s[15] ? (17'h1_0000 - {1'b0, s}) : {1'b0, s};
      if (mag > 17'h0_7F7B) begin
        mag = 17'h0_7F7B;
      end
      mag = mag + 17'h0_0084;
      ex = 3'd0;
      for (i = 0; i < 8; i = i + 1) begin
        if (mag[i + 7]) begin
          ex = i[2:0];
        end
      end
      man = mag[ex + 3 +: 4];
      ulawEnc = ~{s[15], ex, man};
    end
  endfunction

  // ----------------------------------------
  // A-law on 12-bit magnitude, even bits inverted
  // ----------------------------------------
  function [7:0] alawEnc;
    input [15:0] s;
    reg [16:0] full;
    reg [11:0] mag;
    reg [2:0] ex;
    reg [3:0] man;
    integer i;
    begin
      full = s[15] ? (17'h1_0000 - {1'b0, s}) : {1'b0, s};
      mag = full[15] ? 12'hFFF : full[14:3];
      ex = 3'd0;
      for (i = 5; i < 12; i = i + 1) begin
        if (mag[i]) begin
          ex = i[2:0] - 3'd4;
        end
      end
      man = (ex == 3'd0) ? mag[4:1] : mag[ex +: 4];
      alawEnc = {~s[15], ex, man} ^ 8'h55;
    end
  endfunction

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      codeOut_r <= 16'h0000;
      codeValid_r <= 1'b0;
    end else if (ce) begin
      codeValid_r <= sampleValid;
      if (sampleValid) begin
        case (fmt)
          `FMT_LIN16: codeOut_r <= sampleIn;
          `FMT_UNS8: codeOut_r <= {8'h00, ~sampleIn[15], sampleIn[14:8]};
          `FMT_ULAW: codeOut_r <= {8'h00, ulawEnc(sampleIn)};
          `FMT_ALAW: codeOut_r <= {8'h00, alawEnc(sampleIn)};
          default: codeOut_r <= sampleIn;
        endcase
      end
    end
  end

endmodule

// ---- rtl/codec_ctrl.v ----
// Codec control: mode change, calibration, rate-change resync, formats, APB registers
`timescale 1ns/1ps
`include "codec_ctrl_consts.vh"

module codec_ctrl #(
  parameter [21:0] RESYNC_FIRST_SCLKS = `RESYNC_FIRST_SCLKS,
  parameter [21:0] RESYNC_LATER_SCLKS = `RESYNC_LATER_SCLKS,
  parameter [8:0] CAL_SAMPLES = `CAL_SAMPLES,
  parameter [8:0] MUTE_SAMPLES = `MUTE_SAMPLES
) (
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire sclkPin,
  input wire frameSyncIn,
  input wire lastSampleIn,
  input wire sampleTick,
  input wire [15:0] adcSample,
  input wire adcValid,
  output reg [15:0] dacSample_r,
  output wire converterCal,
  output wire outputMute,
  output wire serialPortEnable,
  output wire frameSyncEnable,
  output wire [2:0] clockDivideSelect,
  output wire clockSourceSelect,
  output wire [1:0] sampleFormat,
  output wire [7:0] miscConfig,
  output wire irq
);

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire access = psel & penable & ce;
  wire wrEn = access & pwrite;
  wire mapped = (paddr == `OFS_CTRL) | (paddr == `OFS_STATUS) | (paddr == `OFS_IRQ_STAT) |
                (paddr == `OFS_IRQ_CLR) | (paddr == `OFS_IRQ_EN) |
                (paddr == `OFS_DAC_DATA) | (paddr == `OFS_ADC_CODE);

  // Zero wait states; while ce is low the slave stalls rather than drop a transfer
  assign pready = ce;
  assign pslverr = psel & penable & ~mapped;

  reg [15:0] ctrl_r;
  reg [15:0] dacData_r;
  reg [`EV_COUNT-1:0] irqStat_r;
  reg [`EV_COUNT-1:0] irqEn_r;
  wire [15:0] adcCode;
  wire adcCodeValid;

  wire modeChange = ctrl_r[`CTRL_MODE_CHANGE];
  assign clockDivideSelect = ctrl_r[`CTRL_CDS_HI:`CTRL_CDS_LO];
  assign clockSourceSelect = ctrl_r[`CTRL_CSS];
  assign sampleFormat = ctrl_r[`CTRL_FMT_HI:`CTRL_FMT_LO];
  assign miscConfig = ctrl_r[`CTRL_MISC_HI:`CTRL_MISC_LO];

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  wire ctrlWr = wrEn & (paddr == `OFS_CTRL);
  // The word that sets mode change may carry the new settings too
  wire settingsOpen = modeChange | pwdata[`CTRL_MODE_CHANGE];
  wire [15:0] guarded = {pwdata[15:1] & {15{settingsOpen}}, 1'b0} |
                        {ctrl_r[15:1] & {15{~settingsOpen}}, 1'b0};
  wire [15:0] ctrl_nxt = {guarded[15:1], pwdata[`CTRL_MODE_CHANGE]};
  wire writeIgnored = ctrlWr & ~settingsOpen & (pwdata[15:1] != ctrl_r[15:1]);
  wire clockChange = ctrlWr & settingsOpen &
                     (ctrl_nxt[`CTRL_CSS:`CTRL_CDS_LO] != ctrl_r[`CTRL_CSS:`CTRL_CDS_LO]);
  wire mceExit = ctrlWr & modeChange & ~pwdata[`CTRL_MODE_CHANGE];
  // The exit word is still taken in mode change, so its own calibrate bit decides
  wire calOnExit = ctrl_nxt[`CTRL_CAL_ON_EXIT];

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `CTRL_RESET;
      dacData_r <= 16'h0000;
      irqEn_r <= {`EV_COUNT{1'b0}};
    end else if (ce) begin
      if (ctrlWr) begin
        ctrl_r <= ctrl_nxt;
      end
      if (wrEn & (paddr == `OFS_DAC_DATA)) begin
        dacData_r <= pwdata[15:0];
      end
      if (wrEn & (paddr == `OFS_IRQ_EN)) begin
        irqEn_r <= pwdata[`EV_COUNT-1:0];
      end
    end
  end

  // ----------------------------------------
  // Calibration and post-exit mute
  // ----------------------------------------
  reg calBusy_r;
  reg calMode_r;
  reg [8:0] calCount_r;
  wire calDone = calBusy_r & sampleTick & (calCount_r == 9'd1);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      calBusy_r <= 1'b0;
      calMode_r <= 1'b0;
      calCount_r <= 9'd0;
    end else if (ce) begin
      if (mceExit) begin
        calBusy_r <= 1'b1;
        calMode_r <= calOnExit;
        calCount_r <= calOnExit ? CAL_SAMPLES : MUTE_SAMPLES;
      end else if (calBusy_r & sampleTick) begin
        calCount_r <= calCount_r - 9'd1;
        if (calCount_r == 9'd1) begin
          calBusy_r <= 1'b0;
        end
      end
    end
  end

  assign converterCal = calBusy_r & calMode_r;
  assign outputMute = calBusy_r;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dacSample_r <= 16'h0000;
    end else if (ce) begin
      dacSample_r <= calBusy_r ? 16'h0000 : dacData_r;
    end
  end

  // ----------------------------------------
  // Serial clock synchroniser and edge
  // ----------------------------------------
  reg sclkMeta_r;
  reg sclkSync_r;
  reg sclkPrev_r;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclkMeta_r <= 1'b0;
      sclkSync_r <= 1'b0;
      sclkPrev_r <= 1'b0;
    end else if (ce) begin
      sclkMeta_r <= sclkPin;
      sclkSync_r <= sclkMeta_r;
      sclkPrev_r <= sclkSync_r;
    end
  end
  wire sclkRise = sclkSync_r & ~sclkPrev_r;

  // ----------------------------------------
  // Rate-change resync sequencer
  // ----------------------------------------
  localparam [2:0] RS_IDLE = 3'd0;
  localparam [2:0] RS_WAIT_FRAME = 3'd1;
  localparam [2:0] RS_WAIT_LAST = 3'd2;
  localparam [2:0] RS_TIMEOUT = 3'd3;
  localparam [2:0] RS_WAIT_SYNC = 3'd4;

  reg [2:0] rsState_r;
  reg [21:0] rsCount_r;
  reg resyncFlag_r;
  reg firstDone_r;
  wire resyncSet = (rsState_r == RS_WAIT_LAST) & lastSampleIn;
  wire portReady = (rsState_r == RS_WAIT_SYNC) & frameSyncIn;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsState_r <= RS_IDLE;
      rsCount_r <= 22'h00_0000;
      resyncFlag_r <= 1'b0;
      firstDone_r <= 1'b0;
    end else if (ce) begin
      case (rsState_r)
        RS_IDLE: begin
          if (clockChange) begin
            rsState_r <= RS_WAIT_FRAME;
          end
        end
        RS_WAIT_FRAME: begin
          // The frame in progress at the write does not count
          if (frameSyncIn) begin
            rsState_r <= RS_WAIT_LAST;
          end
        end
        RS_WAIT_LAST: begin
          if (lastSampleIn) begin
            resyncFlag_r <= 1'b1;
            rsCount_r <= firstDone_r ? RESYNC_LATER_SCLKS : RESYNC_FIRST_SCLKS;
            rsState_r <= RS_TIMEOUT;
          end
        end
        RS_TIMEOUT: begin
          if (sclkRise) begin
            rsCount_r <= rsCount_r - 22'h00_0001;
            if (rsCount_r == 22'h00_0001) begin
              rsState_r <= RS_WAIT_SYNC;
            end
          end
        end
        RS_WAIT_SYNC: begin
          if (frameSyncIn) begin
            resyncFlag_r <= 1'b0;
            firstDone_r <= 1'b1;
            rsState_r <= clockChange ? RS_WAIT_FRAME : RS_IDLE;
          end
        end
        default: begin
          rsState_r <= RS_IDLE;
        end
      endcase
    end
  end

  wire portOff = (rsState_r == RS_TIMEOUT);
  // The port comes back once the timeout ends so the first frame sync is answered
  assign serialPortEnable = ~portOff;
  assign frameSyncEnable = ~portOff;

  // ----------------------------------------
  // Capture sample encoding
  // ----------------------------------------
  sample_formatter i_sample_formatter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .fmt(sampleFormat),
    .sampleIn(calBusy_r ? 16'h0000 : adcSample),
    .sampleValid(adcValid),
    .codeOut_r(adcCode),
    .codeValid_r(adcCodeValid)
  );

  reg [15:0] adcHold_r;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      adcHold_r <= 16'h0000;
    end else if (ce & adcCodeValid) begin
      adcHold_r <= adcCode;
    end
  end

  // ----------------------------------------
  // Interrupts: set beats a same-cycle clear
  // ----------------------------------------
  wire [`EV_COUNT-1:0] events = {writeIgnored, portReady, resyncSet, calDone};
  wire [`EV_COUNT-1:0] clrMask = (wrEn & (paddr == `OFS_IRQ_CLR)) ?
                                 pwdata[`EV_COUNT-1:0] : {`EV_COUNT{1'b0}};
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_r <= {`EV_COUNT{1'b0}};
    end else if (ce) begin
      irqStat_r <= (irqStat_r & ~clrMask) | events;
    end
  end
  assign irq = |(irqStat_r & irqEn_r);

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [3:0] status = {firstDone_r, portOff, resyncFlag_r, calBusy_r};

  always @* begin
    case (paddr)
      `OFS_CTRL: prdata = {16'h0000, ctrl_r};
      `OFS_STATUS: prdata = {28'h000_0000, status};
      `OFS_IRQ_STAT: prdata = {28'h000_0000, irqStat_r};
      `OFS_IRQ_EN: prdata = {28'h000_0000, irqEn_r};
      `OFS_DAC_DATA: prdata = {16'h0000, dacData_r};
      `OFS_ADC_CODE: prdata = {16'h0000, adcHold_r};
      default: prdata = 32'h0000_0000;
    endcase
  end

endmodule

// ---- bench/codec_ctrl_assertions.sv ----
// Port-level checks of the codec control block
`timescale 1ns/1ps
module codec_ctrl_assertions #(
  parameter [21:0] RESYNC_FIRST_SCLKS = 22'h20_0000,
  parameter [8:0] CAL_SAMPLES = 9'h180,
  parameter [8:0] MUTE_SAMPLES = 9'h080
) (
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire sampleTick,
  input wire lastSampleIn,
  input wire [15:0] dacSample_r,
  input wire converterCal,
  input wire outputMute,
  input wire serialPortEnable,
  input wire frameSyncEnable,
  input wire [1:0] sampleFormat
);
  // Shadow of the mode change bit: that bit itself is not on the ports
  reg modeChg_r;
  reg [8:0] tickCnt_r;
  reg [31:0] offCnt_r;
  wire ctrlWr = psel & penable & pwrite & ce & (paddr == 8'h00);
  wire fmtWr = ctrlWr & (modeChg_r | pwdata[0]);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      modeChg_r <= 1'b1;
      tickCnt_r <= 9'h000;
      offCnt_r <= 32'h0000_0000;
    end else begin
      if (ctrlWr)
        modeChg_r <= pwdata[0];
      tickCnt_r <= outputMute ? tickCnt_r + {8'h00, sampleTick} : 9'h000;
      offCnt_r <= serialPortEnable ? 32'h0000_0000 : offCnt_r + 32'h0000_0001;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence exitWr;
    ctrlWr && modeChg_r && !pwdata[0];
  endsequence
  sequence calExit;
    exitWr ##0 pwdata[1];
  endsequence
  a_exit_sets_busy: assert property (exitWr |=> outputMute)
    else $error("exit left busy low");
  a_cal_on_exit: assert property (calExit |=> converterCal)
    else $error("no calibration on exit");
  a_cal_is_busy: assert property (converterCal |-> outputMute)
    else $error("calibration without busy");
  a_mute_zero_dac: assert property (outputMute && $past(outputMute) |-> dacSample_r == 16'h0000)
    else $error("converter fed while muted");
  a_busy_length: assert property ($fell(outputMute) |-> $past(sampleTick) &&
    tickCnt_r == ($past(converterCal) ? CAL_SAMPLES : MUTE_SAMPLES))
    else $error("busy length wrong");
  a_fmt_locked: assert property ($changed(sampleFormat) |-> $past(fmtWr))
    else $error("format changed outside mode change");
  a_fmt_at_once: assert property (fmtWr |=> sampleFormat == $past(pwdata[7:6]))
    else $error("format write not applied");
  a_port_fs_off: assert property (!serialPortEnable |-> !frameSyncEnable &&
    ($past(!serialPortEnable) || $past(lastSampleIn)))
    else $error("frame syncs while port off");
  a_resync_last: assert property ($fell(serialPortEnable) |-> $past(lastSampleIn))
    else $error("port off away from last sample");
  a_resync_bound: assert property (offCnt_r <= 8 * RESYNC_FIRST_SCLKS + 64)
    else $error("resync timeout overran");
endmodule
bind codec_ctrl codec_ctrl_assertions #(.RESYNC_FIRST_SCLKS(RESYNC_FIRST_SCLKS),
  .CAL_SAMPLES(CAL_SAMPLES), .MUTE_SAMPLES(MUTE_SAMPLES)) i_codec_ctrl_assertions (
  .clk_sys, .rst_n, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .sampleTick,
  .lastSampleIn, .dacSample_r, .converterCal, .outputMute, .serialPortEnable,
  .frameSyncEnable, .sampleFormat);

// ---- bench/frame_source.sv ----
// Serial frame timing of the host port feeding the codec control block
`timescale 1ns/1ps
module frame_source (
  input wire clk_sys,
  input wire rst_n,
  output wire sclkPin,
  output wire frameSyncIn,
  output wire lastSampleIn,
  output wire sampleTick
);
  // Four samples of eight system clocks (two serial clocks) a frame keep calibration and resync short
  reg [4:0] slot_r;
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      slot_r <= 5'h00;
    else
      slot_r <= slot_r + 5'h01;
  assign sclkPin = slot_r[1];
  assign sampleTick = slot_r[2:0] == 3'h7;
  assign lastSampleIn = slot_r == 5'h1F;
  assign frameSyncIn = rst_n && slot_r == 5'h00;
endmodule

// ---- bench/codec_ctrl_test.sv ----
// Self-checking bench for the codec control block
`timescale 1ns/1ps
`include "codec_ctrl_consts.vh"
module codec_ctrl_test;
  localparam [8:0] CAL = 9'h6;
  localparam [8:0] MUTE = 9'h3;
  // Format, capture sample, expected code
  localparam [33:0] VEC [0:6] = '{{`FMT_LIN16, 16'h8000, 16'h8000},
    {`FMT_UNS8, 16'h8000, 16'h0000}, {`FMT_UNS8, 16'h7FFF, 16'h00FF},
    {`FMT_ULAW, 16'h0000, 16'h00FF}, {`FMT_ULAW, 16'h7FFF, 16'h0080},
    {`FMT_ALAW, 16'h0000, 16'h00D5}, {`FMT_ALAW, 16'h7FFF, 16'h00AA}};
  reg clk_sys, rst_n, ce, psel, penable, pwrite, adcValid, slv;
  reg [7:0] paddr;
  reg [15:0] adcSample;
  reg [31:0] pwdata, rv;
  wire [31:0] prdata;
  wire [15:0] dacSample_r;
  wire [7:0] miscConfig;
  wire [2:0] clockDivideSelect;
  wire [1:0] sampleFormat;
  wire pready, pslverr, sclkPin, frameSyncIn, lastSampleIn, sampleTick, converterCal;
  wire outputMute, serialPortEnable, frameSyncEnable, clockSourceSelect, irq;
  integer errCount, checks, ticks, tk, t0, i;
  codec_ctrl #(.RESYNC_FIRST_SCLKS(22'h8), .RESYNC_LATER_SCLKS(22'h4), .CAL_SAMPLES(CAL),
    .MUTE_SAMPLES(MUTE)) i_codec_ctrl (.clk_sys, .rst_n, .ce, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .sclkPin, .frameSyncIn, .lastSampleIn,
    .sampleTick, .adcSample, .adcValid, .dacSample_r, .converterCal, .outputMute,
    .serialPortEnable, .frameSyncEnable, .clockDivideSelect, .clockSourceSelect,
    .sampleFormat, .miscConfig, .irq);
  frame_source i_frame_source (.clk_sys, .rst_n, .sclkPin, .frameSyncIn, .lastSampleIn,
    .sampleTick);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Counted mid-cycle so the tally never races the edge the block samples on
  always @(negedge clk_sys)
    if (sampleTick === 1'b1)
      ticks = ticks + 1;
  task results;
    begin
      $display("checks %0d, mismatches %0d", checks, errCount);
      if (errCount == 0 && checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task stall;
    begin
      errCount = errCount + 1;
      $display("unexpected wait: expected an answer, seen none");
      results;
    end
  endtask
  task chk(input [8*8-1:0] what, input [31:0] exp, input [31:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        errCount = errCount + 1;
        $display("unexpected %0s: expected %h, seen %h", what, exp, got);
      end
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      if (pready !== 1'b1)
        stall;
      rv = prdata;
      slv = pslverr;
      tk = ticks;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task poll(input integer b, input v);
    integer n;
    begin
      n = 0;
      xfer(0, `OFS_STATUS, 0);
      while (rv[b] !== v) begin
        if (n == 300)
          stall;
        xfer(0, `OFS_STATUS, 0);
        n = n + 1;
      end
    end
  endtask
  task tReset;
    begin
      xfer(0, `OFS_CTRL, 0);
      chk("ctrl", 32'h0000_0001, rv);
      xfer(1, `OFS_CTRL, 32'h0000_A501);
      chk("misc", 32'h0000_00A5, miscConfig);
      xfer(0, 8'h1C, 0);
      chk("slverr", 1, slv);
      chk("unmapped", 0, rv);
      ce <= 1'b0;
      @(posedge clk_sys);
      chk("pready", 0, pready);
      ce <= 1'b1;
      $display("reset test done");
    end
  endtask
  task tFormat;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        xfer(1, `OFS_CTRL, {24'h0, VEC[i][33:32], 6'h01});
        chk("format", VEC[i][33:32], sampleFormat);
        adcSample <= VEC[i][31:16];
        adcValid <= 1'b1;
        @(posedge clk_sys);
        adcValid <= 1'b0;
        repeat (3) @(posedge clk_sys);
        xfer(0, `OFS_ADC_CODE, 0);
        chk("code", VEC[i][15:0], rv);
      end
      $display("format test done");
    end
  endtask
  task tExit(input cal, input [8:0] n);
    begin
      xfer(1, `OFS_CTRL, {30'h0, cal, 1'b1});
      xfer(1, `OFS_DAC_DATA, 32'h0000_5A5A);
      xfer(1, `OFS_CTRL, {30'h0, cal, 1'b0});
      t0 = tk;
      // The zeroed converter sample is launched one edge after the flag
      @(posedge clk_sys);
      chk("cal", cal, converterCal);
      chk("mute", 1, outputMute);
      chk("dac", 0, dacSample_r);
      poll(`ST_CAL_BUSY, 1'b1);
      poll(`ST_CAL_BUSY, 1'b0);
      chk("ticks", n, tk - t0);
      chk("dac", 32'h0000_5A5A, dacSample_r);
      $display("exit test done");
    end
  endtask
  task tRefused;
    begin
      xfer(1, `OFS_IRQ_EN, 32'h0000_0008);
      xfer(1, `OFS_CTRL, 32'h0000_5AC0);
      chk("format", 0, sampleFormat);
      chk("misc", 0, miscConfig);
      chk("irq", 1, irq);
      xfer(1, `OFS_IRQ_EN, 0);
      chk("irq", 0, irq);
      xfer(1, `OFS_IRQ_EN, 32'h0000_0008);
      xfer(1, `OFS_IRQ_CLR, 32'h0000_0008);
      chk("irq", 0, irq);
      $display("refused test done");
    end
  endtask
  task tRate(input [31:0] w);
    begin
      xfer(1, `OFS_CTRL, w);
      chk("clocks", w[5:2], {clockSourceSelect, clockDivideSelect});
      poll(`ST_RESYNC, 1'b1);
      chk("port", 0, {serialPortEnable, frameSyncEnable});
      poll(`ST_PORT_OFF, 1'b0);
      chk("port", 3, {serialPortEnable, frameSyncEnable});
      poll(`ST_RESYNC, 1'b0);
      xfer(1, `OFS_CTRL, {w[31:1], 1'b0});
      poll(`ST_CAL_BUSY, 1'b1);
      poll(`ST_CAL_BUSY, 1'b0);
      xfer(0, `OFS_IRQ_STAT, 0);
      chk("events", 32'h0000_0006, rv & 32'h0000_0006);
      xfer(1, `OFS_IRQ_CLR, 32'h0000_000F);
      $display("rate test done");
    end
  endtask
  initial begin
    errCount = 0;
    checks = 0;
    ticks = 0;
    {ce, psel, penable, pwrite, adcValid, paddr, pwdata, adcSample} = 0;
    ce = 1'b1;
    rst_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    tReset;
    tFormat;
    tExit(1'b0, MUTE);
    tRefused;
    tExit(1'b1, CAL);
    tRate(32'h0000_0015);
    tRate(32'h0000_0021);
    results;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    stall;
  end
endmodule
